/* File: sfpi_pkg.sv */
// shared constants and types for the serial flash pin front end
package sfpi_pkg;

   // one-hot lane width of the current transfer phase
   typedef enum logic [2:0] {
      SFPI_W1 = 3'b001,
      SFPI_W2 = 3'b010,
      SFPI_W4 = 3'b100
   } sfpi_width_e;

   localparam int unsigned SFPI_BYTE_BITS   = 8;
   localparam int unsigned SFPI_CNT_W       = 4;
   localparam int unsigned SFPI_SYNC_STAGES = 2;

   // array geometry: address and log2 field widths, then sizes as log2 byte counts
   localparam int unsigned SFPI_ADDR_W      = 18;
   localparam int unsigned SFPI_LOG_W       = 5;
   localparam logic [4:0]  SFPI_SECTOR_LOG2 = 5'h0C;
   localparam logic [4:0]  SFPI_SEC_MAX_LOG2 = 5'h0F;
   localparam logic [4:0]  SFPI_BLOCK_LOG2  = 5'h10;
   localparam logic [4:0]  SFPI_ARRAY_LOG2  = 5'h12;

   // values after reset
   localparam logic [3:0]  SFPI_OE_N_RST    = 4'hF;
   localparam logic [3:0]  SFPI_CNT_RST     = 4'h0;
   localparam logic [7:0]  SFPI_BYTE_RST    = 8'h00;
   localparam logic        SFPI_FOUR_RST    = 1'b0;

endpackage

/* File: sfpi_protect.sv */
// array region decode from the block protect bits
`timescale 1ns/1ps

module sfpi_protect (
   input  wire logic                              protect_complement,
   input  wire logic                              sector_granularity,
   input  wire logic                              top_bottom_select,
   input  wire logic [2:0]                        block_protect,
   input  wire logic [sfpi_pkg::SFPI_ADDR_W-1:0]  check_addr,
   output logic                                   addr_hit
);
   import sfpi_pkg::*;

   logic [SFPI_LOG_W-1:0]  size_log;
   logic [SFPI_ADDR_W-1:0] low_mask;
   logic                   in_top;
   logic                   in_bottom;
   logic                   in_region;
   logic [SFPI_LOG_W-1:0]  sec_log;

   // sector mode grows 4KB by doubling and stops at 32KB
   assign sec_log = SFPI_SECTOR_LOG2 + {2'b00, block_protect} - 5'h01;

   assign size_log =
      sector_granularity ?
         ((block_protect > 3'h4) ? SFPI_SEC_MAX_LOG2 : sec_log) :
      (block_protect > 3'h2) ? SFPI_ARRAY_LOG2 :
         SFPI_BLOCK_LOG2 + {2'b00, block_protect} - 5'h01;

   assign low_mask  = ~({SFPI_ADDR_W{1'b1}} << size_log);
   assign in_top    = &(check_addr | low_mask);
   assign in_bottom = ~|(check_addr & ~low_mask);
   assign in_region = (block_protect != 3'h0) &&
                      (top_bottom_select ? in_bottom : in_top);
   // complement turns the region into its remainder
   assign addr_hit  = in_region ^ protect_complement;

endmodule // sfpi_protect

/* File: sfpi_front.sv */
// pin-level front end: select, shifting, pause and protection gating
`timescale 1ns/1ps

// Functional notes
// - single-line mode samples host bits on the input line at clock rise
// - single-line mode drives read data on the output line at clock fall
// - multi-line modes share lines both ways: sample on rise, drive on fall
// - quad and four-line operations only allowed while quad enable is set
// - with quad enable set, protect and pause pins become lines two, three
// - chip select high deselects and floats every data output
// - internal erase, program or status write continues after deselect
// - chip select low selects: commands accepted, read data returned
// - after power-up commands ignored until one select falling edge
// - pause low while selected floats output, ignores data and clock
// - pause release resumes the operation exactly where it stopped
// - quad enable set removes the pause function from its pin
// - write-protect pin with status protect bits blocks status writes
// - protect bits select a region from one 4KB sector to whole array
// - quad enable set removes the write-protect function from its pin
// - clock modes 0 and 3 both work; host idles clock per mode
// - pause starts and ends at pin edge if clock low, else next fall
// - pause only works in single and dual operation
// - reset state is SPI mode; four-line entry needs quad enable
module sfpi_front (
   input  wire logic                             clk_sys,
   input  wire logic                             rst,
   input  wire logic                             spi_clk_pin,
   input  wire logic                             chip_sel_n_pin,
   input  wire logic                             io_line_0_in,
   input  wire logic                             io_line_1_in,
   input  wire logic                             io_line_2_in,
   input  wire logic                             io_line_3_in,
   output logic                                  io_line_0_out,
   output logic                                  io_line_1_out,
   output logic                                  io_line_2_out,
   output logic                                  io_line_3_out,
   output logic                                  io_line_0_oe_n,
   output logic                                  io_line_1_oe_n,
   output logic                                  io_line_2_oe_n,
   output logic                                  io_line_3_oe_n,
   input  wire logic                             quad_enable_bit,
   input  wire logic [1:0]                       status_protect_bits,
   input  wire logic                             protect_complement,
   input  wire logic                             sector_granularity,
   input  wire logic                             top_bottom_select,
   input  wire logic                             block_protect_2,
   input  wire logic                             block_protect_1,
   input  wire logic                             block_protect_0,
   input  wire sfpi_pkg::sfpi_width_e            width_req,
   input  wire logic                             enter_four_line,
   input  wire logic                             exit_four_line,
   input  wire logic                             soft_reset,
   input  wire logic                             drive_req,
   input  wire logic [7:0]                       tx_data,
   output logic                                  tx_taken,
   output logic [7:0]                            rx_data,
   output logic                                  rx_valid,
   output logic                                  frame_start,
   output logic                                  frame_end,
   output logic                                  selected,
   output logic                                  paused,
   output logic                                  four_line_instruction_mode,
   output sfpi_pkg::sfpi_width_e                 width_active,
   input  wire logic                             cycle_start,
   input  wire logic                             cycle_done,
   output logic                                  cycle_busy,
   input  wire logic [sfpi_pkg::SFPI_ADDR_W-1:0] check_addr,
   output logic                                  addr_protected,
   output logic                                  status_write_ok
);
   import sfpi_pkg::*;

   // pin order in the synchroniser: clk, cs_n, io0..io3
   localparam int unsigned NPIN = 6;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_r;
   logic [NPIN-1:0] sync2_r;
   logic            sclk_s;
   logic            cs_n_s;
   logic [3:0]      io_s;
   logic            sclk_d_r;
   logic            cs_n_d_r;
   logic            armed_r;
   logic            pause_r;
   logic            four_r;
   logic            busy_r;
   logic [7:0]      rx_sh_r;
   logic [3:0]      rx_cnt_r;
   logic [7:0]      rx_data_r;
   logic            rx_valid_r;
   logic [7:0]      tx_sh_r;
   logic [3:0]      tx_cnt_r;
   logic [3:0]      out_r;
   logic [3:0]      oe_n_r;
   logic            prot_r;
   logic            swok_r;
   logic            prot_hit;

   // width-dependent shift step in bits per clock
   function automatic logic [3:0] step_of(input sfpi_width_e w);
      unique case (w)
         SFPI_W1: step_of = 4'h1;
         SFPI_W2: step_of = 4'h2;
         SFPI_W4: step_of = 4'h4;
         default: step_of = 4'h1;
      endcase
   endfunction

   // top bits of a byte placed on {io3,io2,io1,io0}
   function automatic logic [3:0] lanes_of(input logic [7:0] b,
                                           input sfpi_width_e w);
      unique case (w)
         SFPI_W1: lanes_of = {2'b00, b[7], 1'b0};
         SFPI_W2: lanes_of = {2'b00, b[7], b[6]};
         SFPI_W4: lanes_of = b[7:4];
         default: lanes_of = 4'h0;
      endcase
   endfunction

   assign pin_raw = {io_line_3_in, io_line_2_in, io_line_1_in,
                     io_line_0_in, chip_sel_n_pin, spi_clk_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   assign sclk_s = sync2_r[0];
   assign cs_n_s = sync2_r[1];
   assign io_s   = sync2_r[5:2];

   // edges of the sampled pins; clock modes 0 and 3 need no special case
   wire sclk_rise = sclk_s & ~sclk_d_r;
   wire sclk_fall = ~sclk_s & sclk_d_r;
   wire cs_fall   = cs_n_d_r & ~cs_n_s;
   wire cs_rise   = ~cs_n_d_r & cs_n_s;

   // select counts only once a falling edge has been seen since reset
   wire sel_w     = ~cs_n_s & armed_r;

   wire four_on   = four_r & quad_enable_bit;
   wire quad_ok   = quad_enable_bit;
   sfpi_width_e eff_w;
   assign eff_w = four_on ? SFPI_W4 :
                  (width_req == SFPI_W4 && !quad_ok) ? SFPI_W1 :
                  width_req;

   // quad pins carry data, so hold and protect lose their pin function
   wire pause_ok  = !quad_enable_bit && eff_w != SFPI_W4;
   wire hold_n    = io_s[3];
   wire wp_on     = !quad_enable_bit && !io_s[2];

   wire active    = sel_w & ~pause_r;
   wire [3:0] stp = step_of(eff_w);
   wire [3:0] rx_sum = rx_cnt_r + stp;
   wire rx_take   = active & sclk_rise;
   wire rx_done   = rx_take && rx_sum == 4'(SFPI_BYTE_BITS);
   wire tx_shift  = active & sclk_fall & drive_req;
   wire tx_load   = tx_shift && tx_cnt_r == SFPI_CNT_RST;

   logic [7:0] rx_nxt;
   always_comb begin
      unique case (eff_w)
         SFPI_W1: rx_nxt = {rx_sh_r[6:0], io_s[0]};
         SFPI_W2: rx_nxt = {rx_sh_r[5:0], io_s[1:0]};
         SFPI_W4: rx_nxt = {rx_sh_r[3:0], io_s[3:0]};
         default: rx_nxt = rx_sh_r;
      endcase
   end

   wire [7:0] tx_src = tx_load ? tx_data : tx_sh_r;
   wire [3:0] oe_on  = {eff_w == SFPI_W4, eff_w == SFPI_W4, 1'b1,
                        eff_w != SFPI_W1};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b0;
         armed_r  <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         cs_n_d_r <= cs_n_s;
         if (cs_fall)
            armed_r <= 1'b1;
      end
   end

   // pause follows the pin only while the clock is low
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         pause_r <= 1'b0;
      else if (!sel_w)
         pause_r <= 1'b0;
      else if (!pause_ok)
         pause_r <= 1'b0;
      else if (!sclk_s)
         pause_r <= pause_ok & ~hold_n;
   end

   // leaving four-line mode when quad enable drops is done by four_on
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         four_r <= SFPI_FOUR_RST;
      else if (soft_reset || exit_four_line)
         four_r <= 1'b0;
      else if (enter_four_line && quad_enable_bit)
         four_r <= 1'b1;
   end

   // not tied to select: the array cycle outlives the frame; set wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         busy_r <= 1'b0;
      else if (cycle_start)
         busy_r <= 1'b1;
      else if (cycle_done)
         busy_r <= 1'b0;
   end

   // bit counts are cleared on deselect, shift registers keep their bits; a pause leaves all untouched
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_sh_r    <= SFPI_BYTE_RST;
         rx_cnt_r   <= SFPI_CNT_RST;
         rx_data_r  <= SFPI_BYTE_RST;
         rx_valid_r <= 1'b0;
      end else begin
         rx_valid_r <= rx_done;
         if (!sel_w) begin
            rx_cnt_r <= SFPI_CNT_RST;
         end else if (rx_take) begin
            rx_sh_r  <= rx_nxt;
            rx_cnt_r <= rx_done ? SFPI_CNT_RST : rx_sum;
         end
         if (rx_done)
            rx_data_r <= rx_nxt;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_sh_r  <= SFPI_BYTE_RST;
         tx_cnt_r <= SFPI_CNT_RST;
         out_r    <= 4'h0;
      end else if (!sel_w) begin
         tx_cnt_r <= SFPI_CNT_RST;
      end else if (tx_shift) begin
         out_r    <= lanes_of(tx_src, eff_w);
         tx_sh_r  <= tx_src << stp;
         tx_cnt_r <= (tx_load ? 4'(SFPI_BYTE_BITS) : tx_cnt_r) - stp;
      end
   end

   // enables low only while selected, unpaused and in a read phase
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         oe_n_r <= SFPI_OE_N_RST;
      else
         oe_n_r <= ~(oe_on & {4{active & drive_req}});
   end

   sfpi_protect u_protect (
      .protect_complement (protect_complement),
      .sector_granularity (sector_granularity),
      .top_bottom_select  (top_bottom_select),
      .block_protect      ({block_protect_2, block_protect_1,
                            block_protect_0}),
      .check_addr         (check_addr),
      .addr_hit           (prot_hit)
   );

   // lock bit blocks always; the low bit only with the pin asserted
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prot_r <= 1'b1;
         swok_r <= 1'b0;
      end else begin
         prot_r <= prot_hit;
         swok_r <= !status_protect_bits[1] &&
                   !(status_protect_bits[0] && wp_on);
      end
   end

   assign io_line_0_out  = out_r[0];
   assign io_line_1_out  = out_r[1];
   assign io_line_2_out  = out_r[2];
   assign io_line_3_out  = out_r[3];
   assign io_line_0_oe_n = oe_n_r[0];
   assign io_line_1_oe_n = oe_n_r[1];
   assign io_line_2_oe_n = oe_n_r[2];
   assign io_line_3_oe_n = oe_n_r[3];

   assign tx_taken       = tx_load;
   assign rx_data        = rx_data_r;
   assign rx_valid       = rx_valid_r;
   assign frame_start    = cs_fall;
   assign frame_end      = cs_rise & armed_r;
   assign selected       = sel_w;
   assign paused         = pause_r;
   assign four_line_instruction_mode = four_r;
   assign width_active   = eff_w;
   assign cycle_busy     = busy_r;
   assign addr_protected = prot_r;
   assign status_write_ok = swok_r;

endmodule // sfpi_front

/* File: sfpi_front_sva.sv */
// concurrent checks on the pin front end ports
`timescale 1ns/1ps
module sfpi_front_sva (
   input wire logic                  clk_sys,
   input wire logic                  rst,
   input wire logic                  chip_sel_n_pin,
   input wire logic                  io_line_0_oe_n,
   input wire logic                  io_line_1_oe_n,
   input wire logic                  io_line_2_oe_n,
   input wire logic                  io_line_3_oe_n,
   input wire logic                  quad_enable_bit,
   input wire logic [1:0]            status_protect_bits,
   input wire logic                  enter_four_line,
   input wire logic                  soft_reset,
   input wire logic                  four_line_instruction_mode,
   input wire sfpi_pkg::sfpi_width_e width_active,
   input wire logic                  paused,
   input wire logic                  cycle_start,
   input wire logic                  cycle_done,
   input wire logic                  cycle_busy,
   input wire logic                  status_write_ok
);
   import sfpi_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // two sync flops plus the output register
   a_desel_floats: assert property (chip_sel_n_pin [*4] |=>
      &{io_line_0_oe_n, io_line_1_oe_n, io_line_2_oe_n, io_line_3_oe_n})
      else $error("output enabled while deselected");
   a_single_in: assert property ((width_active == SFPI_W1) [*2] |->
      io_line_0_oe_n) else $error("input line driven in single mode");
   a_quad_gated: assert property (!quad_enable_bit |->
      width_active != SFPI_W4) else $error("quad width without enable");
   a_enter_gated: assert property (enter_four_line && !quad_enable_bit
      && !four_line_instruction_mode |=> !four_line_instruction_mode)
      else $error("four-line mode entered without enable");
   a_reset_spi: assert property (soft_reset |=>
      !four_line_instruction_mode) else $error("soft reset kept four-line");
   a_no_pause_qe: assert property (quad_enable_bit [*3] |-> !paused)
      else $error("paused while quad enable set");
   a_no_pause_quad: assert property ((width_active == SFPI_W4) [*3] |->
      !paused) else $error("paused during quad transfer");
   a_pause_floats: assert property (paused [*2] |-> io_line_1_oe_n)
      else $error("output driven while paused");
   a_lock_blocks: assert property (status_protect_bits[1] |=>
      !status_write_ok) else $error("status write allowed while locked");
   a_qe_frees_wp: assert property (quad_enable_bit &&
      !status_protect_bits[1] |=> status_write_ok)
      else $error("status write blocked with quad enable set");
   a_cycle_holds: assert property (cycle_start || cycle_busy &&
      !cycle_done |=> cycle_busy) else $error("internal cycle dropped");
   c_pause: cover property (paused);
   c_four_line: cover property ($rose(four_line_instruction_mode));
   c_busy_desel: cover property (cycle_busy && chip_sel_n_pin);
endmodule // sfpi_front_sva

bind sfpi_front sfpi_front_sva sfpi_front_sva_i (.*);

/* File: sfpi_host_model.sv */
// host side of the serial link: clock, select and data lanes
`timescale 1ns/1ps
module sfpi_host_model (
   input  wire logic       clk_sys,
   input  wire logic [3:0] dout,
   input  wire logic [3:0] oe_n,
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      line
);
   logic [3:0] hval;
   logic [3:0] hen;
   int         hp = 8;
   bit         idle_hi = 1'b0;
   // released lanes settle to the pull-ups; device drive wins
   assign line = (~oe_n & dout) | (oe_n & hen & hval) | (oe_n & ~hen);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      hval = 4'hF;
      hen = 4'hC;
   end
   // hp clocks a half period; three is the fastest the front end takes
   task automatic half_wait();
      repeat (hp) @(posedge clk_sys);
      #1;
   endtask
   task automatic begin_frame();
      sclk = idle_hi;
      half_wait();
      cs_n = 1'b0;
      half_wait();
   endtask
   task automatic end_frame();
      sclk = idle_hi;
      half_wait();
      cs_n = 1'b1;
      hval = 4'hF;
      half_wait();
      half_wait();
   endtask
   // n lanes per clock; rd hands the lanes to the device
   task automatic xfer(input logic [7:0] tx, input int n, input bit rd,
                       output logic [7:0] rx);
      logic [3:0] m;
      logic [3:0] save;
      m = (n == 1) ? 4'h1 : (n == 2) ? 4'h3 : 4'hF;
      save = hen;
      rx = 8'h00;
      hen = rd ? (hen & ~m) : (hen | m);
      for (int c = 0; c < 8 / n; c++) begin
         sclk = 1'b0;
         if (!rd)
            hval = (hval & ~m) | (m & (tx[7:4] >> (4 - n)));
         tx = tx << n;
         half_wait();
         rx = (rx << n) | ((n == 1) ? {7'h00, line[1]} : {4'h0, line & m});
         sclk = 1'b1;
         half_wait();
      end
      hen = save;
   endtask
endmodule // sfpi_host_model

/* File: sfpi_front_tb.sv */
// self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
module sfpi_front_tb;
   import sfpi_pkg::*;
   logic        clk_sys, rst, spi_clk_pin, chip_sel_n_pin, quad_enable_bit;
   wire logic   io_line_0_in, io_line_1_in, io_line_2_in, io_line_3_in;
   logic        io_line_0_out, io_line_1_out, io_line_2_out, io_line_3_out;
   logic        io_line_0_oe_n, io_line_1_oe_n, io_line_2_oe_n, io_line_3_oe_n;
   logic [1:0]  status_protect_bits;
   logic        protect_complement, sector_granularity, top_bottom_select;
   logic        block_protect_2, block_protect_1, block_protect_0;
   sfpi_width_e width_req, width_active;
   logic        enter_four_line, exit_four_line, soft_reset, drive_req;
   logic [7:0]  tx_data, rx_data, rx_last, rd;
   logic        tx_taken, rx_valid, frame_start, frame_end, selected, paused;
   logic        four_line_instruction_mode, cycle_start, cycle_done;
   logic        cycle_busy, addr_protected, status_write_ok;
   logic [17:0] check_addr;
   int          rx_cnt = 0, miscompares = 0, checked = 0, c0;
   int          tt_cnt = 0, fs_cnt = 0, fe_cnt = 0;

   sfpi_front sfpi_front_i (.*);
   sfpi_host_model sfpi_host_model_i (
      .clk_sys (clk_sys),
      .dout    ({io_line_3_out, io_line_2_out, io_line_1_out,
                 io_line_0_out}),
      .oe_n    ({io_line_3_oe_n, io_line_2_oe_n, io_line_1_oe_n,
                 io_line_0_oe_n}),
      .sclk    (spi_clk_pin),
      .cs_n    (chip_sel_n_pin),
      .line    ({io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in})
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) begin
         rx_cnt <= rx_cnt + 1;
         rx_last <= rx_data;
      end
      if (tx_taken === 1'b1)
         tt_cnt <= tt_cnt + 1;
      if (frame_start === 1'b1)
         fs_cnt <= fs_cnt + 1;
      if (frame_end === 1'b1)
         fe_cnt <= fe_cnt + 1;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
      step(1);
   endtask
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_byte(input string nm, input logic [7:0] e,
                             input logic [7:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check_bit(input string nm, input logic e, input logic g);
      check_byte(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic send(input logic [7:0] b, input int n);
      int want;
      want = rx_cnt + 1;
      sfpi_host_model_i.xfer(b, n, 1'b0, rd);
      for (int i = 0; i < 40 && rx_cnt < want; i++) step(1);
      if (rx_cnt < want) begin
         miscompares++;
         summarize();
      end
      check_byte("rx_data", b, rx_last);
   endtask
   task automatic fetch(input logic [7:0] b, input int n);
      int t0;
      t0 = tt_cnt;
      drive_req = 1'b1;
      tx_data = b;
      sfpi_host_model_i.xfer(8'h00, n, 1'b1, rd);
      drive_req = 1'b0;
      check_byte("read byte", b, rd);
      check_byte("bytes loaded", 8'(t0 + 1), 8'(tt_cnt));
   endtask
   task automatic prot(input logic [5:0] cfg, input logic [17:0] a,
                       input logic e);
      {protect_complement, sector_granularity, top_bottom_select,
       block_protect_2, block_protect_1, block_protect_0} = cfg;
      check_addr = a;
      step(2);
      check_bit("addr_protected", e, addr_protected);
   endtask

   initial begin
      rst = 1'b1;
      {quad_enable_bit, protect_complement, sector_granularity,
       top_bottom_select, block_protect_2, block_protect_1, block_protect_0,
       enter_four_line, exit_four_line, soft_reset, drive_req, cycle_start,
       cycle_done} = 13'h0000;
      status_protect_bits = 2'h0;
      tx_data = 8'h00;
      check_addr = 18'h00000;
      width_req = SFPI_W1;
      step(3);
      rst = 1'b0;
      // select low since power-up: the link must stay ignored
      sfpi_host_model_i.xfer(8'hA5, 1, 1'b0, rd);
      check_bit("selected", 1'b0, selected);
      check_byte("bytes taken", 8'h00, 8'(rx_cnt));
      sfpi_host_model_i.end_frame();
      quad_enable_bit = 1'b1;
      for (int k = 0; k < 3; k++) begin
         width_req = sfpi_width_e'(3'h1 << k);
         sfpi_host_model_i.begin_frame();
         check_bit("selected", 1'b1, selected);
         send(8'hA5 + 8'(k), 1 << k);
         fetch(8'h3C + 8'(k), 1 << k);
         // output phase left open so only deselect can float the lines
         drive_req = 1'b1;
         sfpi_host_model_i.end_frame();
         check_bit("lines floated", 1'b1, &{io_line_0_oe_n, io_line_1_oe_n,
                   io_line_2_oe_n, io_line_3_oe_n});
         drive_req = 1'b0;
      end
      check_byte("frame starts", 8'h03, 8'(fs_cnt));
      check_byte("frame ends", 8'h03, 8'(fe_cnt));
      // quad asked without enable falls back to one lane, clock mode 3
      quad_enable_bit = 1'b0;
      sfpi_host_model_i.idle_hi = 1'b1;
      sfpi_host_model_i.begin_frame();
      check_byte("width", 8'(SFPI_W1), 8'(width_active));
      send(8'h69, 1);
      fetch(8'h96, 1);
      sfpi_host_model_i.end_frame();
      sfpi_host_model_i.idle_hi = 1'b0;
      width_req = SFPI_W1;
      sfpi_host_model_i.begin_frame();
      send(8'hC3, 1);
      c0 = rx_cnt;
      sfpi_host_model_i.hval[3] = 1'b0;
      step(8);
      // clock still high: the pause waits for the next fall
      check_bit("paused", 1'b0, paused);
      sfpi_host_model_i.xfer(8'hFF, 1, 1'b0, rd);
      sfpi_host_model_i.hval[3] = 1'b1;
      step(8);
      check_bit("paused", 1'b1, paused);
      send(8'h5A, 1);
      check_byte("bytes taken", 8'(c0 + 1), 8'(rx_cnt));
      quad_enable_bit = 1'b1;
      sfpi_host_model_i.hval[3] = 1'b0;
      // clock low, so without quad enable the pause would start at once
      sfpi_host_model_i.sclk = 1'b0;
      step(8);
      check_bit("paused", 1'b0, paused);
      cycle_start = 1'b1;
      step(1);
      cycle_start = 1'b0;
      sfpi_host_model_i.end_frame();
      check_bit("cycle_busy", 1'b1, cycle_busy);
      pulse(cycle_done);
      check_bit("cycle_busy", 1'b0, cycle_busy);
      for (int i = 0; i < 16; i++) begin
         {status_protect_bits, quad_enable_bit} = 3'(i);
         sfpi_host_model_i.hval[2] = i[3];
         step(5);
         check_bit("status_write_ok", !i[2] && !(i[1] && !i[3] && !i[0]),
                   status_write_ok);
      end
      prot(6'h00, 18'h00000, 1'b0);
      prot(6'h19, 18'h00FFF, 1'b1);
      prot(6'h19, 18'h01000, 1'b0);
      prot(6'h39, 18'h00FFF, 1'b0);
      prot(6'h01, 18'h30000, 1'b1);
      prot(6'h01, 18'h2FFFF, 1'b0);
      prot(6'h03, 18'h00000, 1'b1);
      prot(6'h20, 18'h12345, 1'b1);
      quad_enable_bit = 1'b0;
      pulse(enter_four_line);
      check_bit("four-line", 1'b0, four_line_instruction_mode);
      quad_enable_bit = 1'b1;
      pulse(enter_four_line);
      check_bit("four-line", 1'b1, four_line_instruction_mode);
      pulse(exit_four_line);
      check_bit("four-line", 1'b0, four_line_instruction_mode);
      pulse(enter_four_line);
      pulse(soft_reset);
      check_bit("four-line", 1'b0, four_line_instruction_mode);
      summarize();
   end
endmodule // sfpi_front_tb
